// [src/pmc_pkg.sv]
/*
  pmc_pkg: register map, field positions, reset values and state types of the
  power mode controller.
  assumes: a single 125 MHz clock domain; word-aligned AHB-Lite register access.
*/
package pmc_pkg;

  // ****************************************************************
  // register byte addresses
  // ****************************************************************
  localparam logic [7:0] PMC_CTRL_ADDR   = 8'h00;
  localparam logic [7:0] PMC_STAT_ADDR   = 8'h04;
  localparam logic [7:0] PMC_IRQ_ADDR    = 8'h08;
  localparam logic [7:0] PMC_MASK_ADDR   = 8'h0c;
  localparam logic [7:0] PMC_ENTER_ADDR  = 8'h10;

  // ****************************************************************
  // control register fields
  // ****************************************************************
  localparam int CTRL_DET_EN_BIT   = 0;
  localparam int CTRL_STOP_LP_BIT  = 1;
  localparam int CTRL_DEEP_BIT     = 2;
  localparam int CTRL_STBY_BIT     = 3;
  localparam logic [3:0] CTRL_RESET = 4'h0;

  // ****************************************************************
  // interrupt status and mask bits
  // ****************************************************************
  localparam int IRQ_FALL_BIT  = 0;
  localparam int IRQ_RISE_BIT  = 1;
  localparam int IRQ_WAKE_BIT  = 2;
  localparam int IRQ_W         = 3;
  localparam logic [2:0] IRQ_RESET  = 3'h0;
  localparam logic [2:0] MASK_RESET = 3'h0;

  // ****************************************************************
  // counts and widths
  // ****************************************************************
  localparam int EXT_LINES = 16;
  localparam int RST_HOLD_NS = 1000;
  localparam int CLK_PERIOD_NS = 8;
  localparam int RST_HOLD_CYC = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_STAGES = 2;

  // ****************************************************************
  // power states
  // ****************************************************************
  typedef enum logic [2:0] {
    PMC_RESET,
    PMC_RUN,
    PMC_SLEEP,
    PMC_STOP,
    PMC_STANDBY
  } pmc_state_t;

endpackage

// [src/pmc_sync.sv]
/*
  pmc_sync: two flip-flop synchroniser for one level.
  assumes: input may change at any time relative to the clock.
*/
`timescale 1ns/1ps
`default_nettype none
module pmc_sync (
  input  wire logic clk_in,     // clock
  input  wire logic reset_n_in, // async reset, active low
  input  wire logic d_in,       // raw level
  output logic      q_out       // synchronised level
);
  logic meta;
  logic next_meta;
  logic next_q;

  always_comb begin
    next_meta = d_in;
    next_q    = meta;
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      meta  <= 1'b0;
      q_out <= 1'b0;
    end else begin
      meta  <= next_meta;
      q_out <= next_q;
    end
  end
endmodule
`default_nettype wire

// [src/pmc_top.sv]
/*
  pmc_top: power mode controller. supervises supply resets, drives the
  supply threshold detector interrupt, selects regulator mode and sequences
  sleep, stop and standby with clock gating and wake-up.
  assumes: analog comparators give asynchronous levels; the core asserts
  its sleep request for one cycle when it executes a wait instruction.
*/
`timescale 1ns/1ps
`default_nettype none
module pmc_top
  import pmc_pkg::*;
(
  input  wire logic        CLK_IN,                 // 125 MHz clock
  input  wire logic        RESET_N_IN,             // async reset, active low
  input  wire logic        HSEL_IN,                // ahb select
  input  wire logic [31:0] HADDR_IN,               // ahb address
  input  wire logic [1:0]  HTRANS_IN,              // ahb transfer type
  input  wire logic        HWRITE_IN,              // ahb write
  input  wire logic [2:0]  HSIZE_IN,               // ahb size
  input  wire logic [31:0] HWDATA_IN,              // ahb write data
  input  wire logic        HREADY_IN,              // ahb bus ready
  output logic [31:0]      HRDATA_OUT,             // ahb read data
  output logic             HREADYOUT_OUT,          // ahb slave ready
  output logic             HRESP_OUT,              // ahb response, always okay
  input  wire logic        SUPPLY_OK_IN,           // supply above por/pdr level
  input  wire logic        DET_ABOVE_IN,           // supply above detector level
  input  wire logic        CORE_SLEEP_REQ_IN,      // core sleep request pulse
  input  wire logic        CORE_EVENT_IN,          // any interrupt or event
  input  wire logic [15:0] EXT_LINE_IN,            // external interrupt lines
  input  wire logic        RTC_EVENT_IN,           // real-time clock event
  input  wire logic        RESET_PIN_LOW_N_IN,     // reset pin, active low
  input  wire logic        WATCHDOG_RESET_IN,      // independent watchdog reset
  input  wire logic        WAKE_UP_PIN_IN,         // wake-up pin level
  output logic             SYS_RESET_N_OUT,        // system reset, active low
  output logic             CORE_CLK_EN_OUT,        // processor clock enable
  output logic             PERIPH_CLK_EN_OUT,      // core domain peripheral clocks
  output logic             PLL_EN_OUT,             // pll enable
  output logic             FAST_OSC_EN_OUT,        // internal fast oscillator enable
  output logic             XTAL_OSC_EN_OUT,        // external crystal oscillator enable
  output logic             REG_EN_OUT,             // regulator enable
  output logic             REG_LOW_POWER_OUT,      // regulator in low-power mode
  output logic             CORE_DOMAIN_PWR_OUT,    // core domain powered
  output logic             BACKUP_CLK_EN_OUT,      // rtc and watchdog clock enable
  output logic             IRQ_OUT                 // interrupt, active high
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic        supply_ok_s;
  logic        above_s;
  logic        wake_pin_s;
  logic        above_q, next_above_q;
  logic        wake_pin_q, next_wake_pin_q;
  logic        det_armed, next_det_armed;
  logic [3:0]  ctrl, next_ctrl;
  logic [2:0]  irq_stat, next_irq_stat;
  logic [2:0]  irq_mask, next_irq_mask;
  pmc_state_t  state, next_state;
  logic [7:0]  hold_cnt, next_hold_cnt;
  logic        ph_valid, next_ph_valid;
  logic        ph_write, next_ph_write;
  logic [7:0]  ph_addr, next_ph_addr;
  logic [31:0] rdata, next_rdata;
  logic        enter_req;
  logic        wr_ctrl, wr_irq, wr_mask, wr_enter;
  logic        det_fall, det_rise, stop_wake, stby_wake;

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  pmc_sync u_sync_supply (
    .clk_in     (CLK_IN),
    .reset_n_in (RESET_N_IN),
    .d_in       (SUPPLY_OK_IN),
    .q_out      (supply_ok_s)
  );

  pmc_sync u_sync_above (
    .clk_in     (CLK_IN),
    .reset_n_in (RESET_N_IN),
    .d_in       (DET_ABOVE_IN),
    .q_out      (above_s)
  );

  pmc_sync u_sync_wake (
    .clk_in     (CLK_IN),
    .reset_n_in (RESET_N_IN),
    .d_in       (WAKE_UP_PIN_IN),
    .q_out      (wake_pin_s)
  );

  // ****************************************************************
  // ahb-lite slave, zero wait states
  // ****************************************************************
  always_comb begin
    next_ph_valid = 1'b0;
    next_ph_write = ph_write;
    next_ph_addr  = ph_addr;
    if (HSEL_IN && HREADY_IN && HTRANS_IN[1]) begin
      next_ph_valid = 1'b1;
      next_ph_write = HWRITE_IN;
      next_ph_addr  = HADDR_IN[7:0];
    end
    wr_ctrl  = ph_valid && ph_write && (ph_addr == PMC_CTRL_ADDR);
    wr_irq   = ph_valid && ph_write && (ph_addr == PMC_IRQ_ADDR);
    wr_mask  = ph_valid && ph_write && (ph_addr == PMC_MASK_ADDR);
    wr_enter = ph_valid && ph_write && (ph_addr == PMC_ENTER_ADDR);
    // read data is captured at the address phase so it comes from a flop
    next_rdata = 32'h0;
    if (HSEL_IN && HREADY_IN && HTRANS_IN[1] && !HWRITE_IN) begin
      case (HADDR_IN[7:0])
        PMC_CTRL_ADDR:  next_rdata = {28'h0, ctrl};
        PMC_STAT_ADDR:  next_rdata = {28'h0, det_armed, above_q,
                                      state == PMC_SLEEP, supply_ok_s};
        PMC_IRQ_ADDR:   next_rdata = {29'h0, irq_stat};
        PMC_MASK_ADDR:  next_rdata = {29'h0, irq_mask};
        default:        next_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      ph_valid <= 1'b0;
      ph_write <= 1'b0;
      ph_addr  <= 8'h00;
      rdata    <= 32'h0;
    end else begin
      ph_valid <= next_ph_valid;
      ph_write <= next_ph_write;
      ph_addr  <= next_ph_addr;
      rdata    <= next_rdata;
    end
  end

  assign HRDATA_OUT    = rdata;
  assign HREADYOUT_OUT = 1'b1;
  assign HRESP_OUT     = 1'b0;

  // ****************************************************************
  // control, detector and interrupt registers
  // ****************************************************************
  always_comb begin
    next_ctrl = ctrl;
    if (wr_ctrl) begin
      next_ctrl = HWDATA_IN[3:0];
    end
    next_above_q   = above_s;
    // detector only arms a cycle after it is enabled; the level is sampled every cycle so arming gives no false edge
    next_det_armed = ctrl[CTRL_DET_EN_BIT];
    det_fall = det_armed && ctrl[CTRL_DET_EN_BIT] && above_q && !above_s;
    det_rise = det_armed && ctrl[CTRL_DET_EN_BIT] && !above_q && above_s;
    next_wake_pin_q = wake_pin_s;
    stop_wake = (|EXT_LINE_IN) || RTC_EVENT_IN;
    stby_wake = (wake_pin_s && !wake_pin_q) || RTC_EVENT_IN
                || !RESET_PIN_LOW_N_IN || WATCHDOG_RESET_IN;
    next_irq_mask = irq_mask;
    if (wr_mask) begin
      next_irq_mask = HWDATA_IN[IRQ_W-1:0];
    end
    // set wins over write-one-to-clear
    next_irq_stat = irq_stat;
    if (wr_irq) begin
      next_irq_stat = irq_stat & ~HWDATA_IN[IRQ_W-1:0];
    end
    if (det_fall) begin
      next_irq_stat[IRQ_FALL_BIT] = 1'b1;
    end
    if (det_rise) begin
      next_irq_stat[IRQ_RISE_BIT] = 1'b1;
    end
    if (state == PMC_STOP && stop_wake) begin
      next_irq_stat[IRQ_WAKE_BIT] = 1'b1;
    end
  end

  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      ctrl       <= CTRL_RESET;
      above_q    <= 1'b0;
      det_armed  <= 1'b0;
      wake_pin_q <= 1'b0;
      irq_mask   <= MASK_RESET;
      irq_stat   <= IRQ_RESET;
    end else if (state == PMC_RESET || state == PMC_STANDBY) begin
      // core domain state is lost in reset and standby
      ctrl       <= CTRL_RESET;
      above_q    <= next_above_q;
      det_armed  <= 1'b0;
      wake_pin_q <= next_wake_pin_q;
      irq_mask   <= MASK_RESET;
      irq_stat   <= IRQ_RESET;
    end else begin
      ctrl       <= next_ctrl;
      above_q    <= next_above_q;
      det_armed  <= next_det_armed;
      wake_pin_q <= next_wake_pin_q;
      irq_mask   <= next_irq_mask;
      irq_stat   <= next_irq_stat;
    end
  end

  assign IRQ_OUT = |(irq_stat & irq_mask);

  // ****************************************************************
  // power state machine
  // ****************************************************************
  always_comb begin
    next_state    = state;
    next_hold_cnt = hold_cnt;
    enter_req     = CORE_SLEEP_REQ_IN || wr_enter;
    case (state)
      PMC_RESET: begin
        if (!supply_ok_s) begin
          next_hold_cnt = 8'h00;
        end else if (hold_cnt == 8'(RST_HOLD_CYC - 1)) begin
          next_state = PMC_RUN;
        end else begin
          next_hold_cnt = hold_cnt + 8'h01;
        end
      end
      PMC_RUN: begin
        if (enter_req) begin
          if (!ctrl[CTRL_DEEP_BIT]) begin
            next_state = PMC_SLEEP;
          end else if (ctrl[CTRL_STBY_BIT]) begin
            next_state = PMC_STANDBY;
          end else begin
            next_state = PMC_STOP;
          end
        end
      end
      PMC_SLEEP: begin
        if (CORE_EVENT_IN || stop_wake) begin
          next_state = PMC_RUN;
        end
      end
      PMC_STOP: begin
        if (stop_wake) begin
          next_state = PMC_RUN;
        end
      end
      PMC_STANDBY: begin
        if (stby_wake) begin
          next_state    = PMC_RESET;
          next_hold_cnt = 8'h00;
        end
      end
      default: begin
        next_state = PMC_RESET;
      end
    endcase
    // supply loss overrides every state
    if (!supply_ok_s) begin
      next_state    = PMC_RESET;
      next_hold_cnt = 8'h00;
    end
  end

  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      state    <= PMC_RESET;
      hold_cnt <= 8'h00;
    end else begin
      state    <= next_state;
      hold_cnt <= next_hold_cnt;
    end
  end

  // ****************************************************************
  // power and clock outputs
  // ****************************************************************
  always_comb begin
    SYS_RESET_N_OUT     = (state != PMC_RESET) && (state != PMC_STANDBY);
    CORE_CLK_EN_OUT     = (state == PMC_RUN);
    PERIPH_CLK_EN_OUT   = (state == PMC_RUN) || (state == PMC_SLEEP);
    PLL_EN_OUT          = PERIPH_CLK_EN_OUT;
    FAST_OSC_EN_OUT     = (state != PMC_STOP) && (state != PMC_STANDBY);
    XTAL_OSC_EN_OUT     = PERIPH_CLK_EN_OUT;
    REG_EN_OUT          = (state != PMC_STANDBY);
    REG_LOW_POWER_OUT   = (state == PMC_STOP) && ctrl[CTRL_STOP_LP_BIT];
    CORE_DOMAIN_PWR_OUT = (state != PMC_STANDBY);
    BACKUP_CLK_EN_OUT   = 1'b1;
  end

endmodule
`default_nettype wire

// [verif/pmc_monitor.sv]
/*
  pmc_monitor: pin-level checks of the power mode controller.
  assumes: bound to pmc_top; one clock, async active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module pmc_monitor
  import pmc_pkg::*;
(
  input wire logic        CLK_IN,              // clock
  input wire logic        RESET_N_IN,          // reset
  input wire logic        SUPPLY_OK_IN,        // supply good
  input wire logic        CORE_EVENT_IN,       // event
  input wire logic [15:0] EXT_LINE_IN,         // lines
  input wire logic        RTC_EVENT_IN,        // clock event
  input wire logic        RESET_PIN_LOW_N_IN,  // reset pin
  input wire logic        WATCHDOG_RESET_IN,   // watchdog
  input wire logic        SYS_RESET_N_OUT,     // sys reset
  input wire logic        CORE_CLK_EN_OUT,     // core clock
  input wire logic        PERIPH_CLK_EN_OUT,   // periph clock
  input wire logic        PLL_EN_OUT,          // pll
  input wire logic        REG_EN_OUT,          // regulator
  input wire logic        REG_LOW_POWER_OUT,   // low power
  input wire logic        CORE_DOMAIN_PWR_OUT, // domain power
  input wire logic        BACKUP_CLK_EN_OUT    // backup clock
);
  // ****************
  // checks
  // ****************
  logic [7:0] low_cnt;
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RESET_N_IN);
  // saturates so a long supply outage cannot wrap it
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      low_cnt <= 8'h0;
    end else if (SYS_RESET_N_OUT) begin
      low_cnt <= 8'h0;
    end else if (low_cnt != 8'hff) begin
      low_cnt <= low_cnt + 8'h1;
    end
  end
  a_supply_loss_reset: assert property ($fell(SUPPLY_OK_IN) |-> ##[1:4] !SYS_RESET_N_OUT)
    else $error("system reset late after supply loss");
  a_reset_hold_time: assert property ($rose(SYS_RESET_N_OUT) |-> low_cnt >= 8'(RST_HOLD_CYC))
    else $error("system reset released too early");
  a_run_main_reg: assert property (CORE_CLK_EN_OUT |-> REG_EN_OUT && !REG_LOW_POWER_OUT)
    else $error("regulator not in main mode while running");
  a_low_power_stop: assert property (REG_LOW_POWER_OUT |-> SYS_RESET_N_OUT && !PERIPH_CLK_EN_OUT)
    else $error("low power regulator outside stop");
  a_sleep_event_wake: assert property (!CORE_CLK_EN_OUT && PERIPH_CLK_EN_OUT && SYS_RESET_N_OUT
    && CORE_EVENT_IN |=> CORE_CLK_EN_OUT)
    else $error("event did not wake sleep");
  a_stop_clocks_off: assert property (SYS_RESET_N_OUT && !PERIPH_CLK_EN_OUT |-> !PLL_EN_OUT
    && !CORE_CLK_EN_OUT && REG_EN_OUT && CORE_DOMAIN_PWR_OUT)
    else $error("stop state outputs wrong");
  a_stop_line_wake: assert property (SYS_RESET_N_OUT && !PERIPH_CLK_EN_OUT
    && (|EXT_LINE_IN || RTC_EVENT_IN) |=> CORE_CLK_EN_OUT)
    else $error("line did not end stop");
  a_standby_power_off: assert property (!CORE_DOMAIN_PWR_OUT |-> !REG_EN_OUT && !PLL_EN_OUT
    && !SYS_RESET_N_OUT)
    else $error("standby outputs wrong");
  a_standby_wake_reset: assert property (!REG_EN_OUT && (RTC_EVENT_IN || WATCHDOG_RESET_IN
    || !RESET_PIN_LOW_N_IN) |=> REG_EN_OUT && !SYS_RESET_N_OUT)
    else $error("standby wake did not restart");
  a_backup_clock_on: assert property ($fell(PERIPH_CLK_EN_OUT) |-> BACKUP_CLK_EN_OUT [*4])
    else $error("backup clock stopped");
  c_sleep: cover property ($fell(CORE_CLK_EN_OUT) && PERIPH_CLK_EN_OUT);
  c_stop: cover property ($fell(PERIPH_CLK_EN_OUT) && SYS_RESET_N_OUT);
  c_standby: cover property ($fell(CORE_DOMAIN_PWR_OUT));
endmodule
`default_nettype wire

// [verif/pmc_partner.sv]
/*
  pmc_partner: core and wake sources facing the controller.
  assumes: the bench starts one action per go pulse.
*/
`timescale 1ns/1ps
`default_nettype none
module pmc_partner (
  input  wire logic        clk_in,      // clock
  input  wire logic        reset_n_in,  // reset
  input  wire logic        go_in,       // start action
  input  wire logic [2:0]  cmd_in,      // action code
  input  wire logic [3:0]  line_in,     // line index
  output logic             slp_out,     // sleep request
  output logic             evt_out,     // core event
  output logic [15:0]      ext_out,     // lines
  output logic             rtc_out,     // clock event
  output logic             wdog_out,    // watchdog
  output logic             rpin_n_out,  // reset pin
  output logic             wkp_out      // wake pin
);
  logic [2:0] src;
  logic [2:0] hold;
  logic [3:0] lsel;
  // core strobes last one cycle; wake sources four, long enough for the pin synchroniser
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      src  <= 3'h0;
      hold <= 3'h0;
      lsel <= 4'h0;
    end else if (go_in) begin
      src  <= cmd_in;
      hold <= (cmd_in < 3'h2) ? 3'h1 : 3'h4;
      lsel <= line_in;
    end else if (hold != 3'h0) begin
      hold <= hold - 3'h1;
    end
  end
  assign slp_out    = (hold != 3'h0) && (src == 3'h0);
  assign evt_out    = (hold != 3'h0) && (src == 3'h1);
  assign ext_out    = ((hold != 3'h0) && (src == 3'h2)) ? (16'h1 << lsel) : 16'h0;
  assign rtc_out    = (hold != 3'h0) && (src == 3'h3);
  assign wdog_out   = (hold != 3'h0) && (src == 3'h4);
  assign rpin_n_out = !((hold != 3'h0) && (src == 3'h5));
  assign wkp_out    = (hold != 3'h0) && (src == 3'h6);
endmodule
`default_nettype wire

// [verif/tb.sv]
/*
  tb: self-checking bench of pmc_top with the partner and checker.
  assumes: zero-wait AHB-Lite slave; outputs decoded from registers.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pmc_pkg::*;
  typedef struct {logic [31:0] v; string n;} pmc_note_t;
  logic        clk = 1'b0, rst_n = 1'b0, supply_ok = 1'b1, det_above = 1'b1;
  logic        hwrite = 1'b0, go = 1'b0, rd_go = 1'b0, pin_go = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, obs;
  logic [2:0]  cmd = 3'h0;
  logic [3:0]  line = 4'h0;
  logic        hready, hresp, sys_n, core_en, per_en, pll, fast, xtal, reg_en, reg_lp;
  logic        dom, bk, irq, slp, evt, rtc, wdog, rpin_n, wkp;
  logic [15:0] ext;
  int          err_count = 0;
  int          cmp_count = 0;
  pmc_note_t   q[$];
  assign obs = {20'h0, hresp, irq, bk, dom, reg_lp, reg_en, xtal, fast, pll, per_en, core_en, sys_n};
  always #4 clk = ~clk;
  pmc_top dut (.CLK_IN(clk), .RESET_N_IN(rst_n), .HSEL_IN(1'b1), .HADDR_IN(haddr),
    .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata),
    .HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
    .SUPPLY_OK_IN(supply_ok), .DET_ABOVE_IN(det_above), .CORE_SLEEP_REQ_IN(slp),
    .CORE_EVENT_IN(evt), .EXT_LINE_IN(ext), .RTC_EVENT_IN(rtc), .RESET_PIN_LOW_N_IN(rpin_n),
    .WATCHDOG_RESET_IN(wdog), .WAKE_UP_PIN_IN(wkp), .SYS_RESET_N_OUT(sys_n),
    .CORE_CLK_EN_OUT(core_en), .PERIPH_CLK_EN_OUT(per_en), .PLL_EN_OUT(pll),
    .FAST_OSC_EN_OUT(fast), .XTAL_OSC_EN_OUT(xtal), .REG_EN_OUT(reg_en),
    .REG_LOW_POWER_OUT(reg_lp), .CORE_DOMAIN_PWR_OUT(dom), .BACKUP_CLK_EN_OUT(bk),
    .IRQ_OUT(irq));
  pmc_partner partner (.clk_in(clk), .reset_n_in(rst_n), .go_in(go), .cmd_in(cmd),
    .line_in(line), .slp_out(slp), .evt_out(evt), .ext_out(ext), .rtc_out(rtc),
    .wdog_out(wdog), .rpin_n_out(rpin_n), .wkp_out(wkp));
  // ****************
  // tasks
  // ****************
  task automatic note(input logic [31:0] v, input string n);
    pmc_note_t e;
    e.v = v;
    e.n = n;
    q.push_back(e);
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= w;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    rd_go  <= !w;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd_go <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] v, input string n);
    note(v, n);
    bus(a, 1'b0, 32'h0);
  endtask
  // pin snapshot is taken at the next edge, before that edge's updates land
  task automatic pins(input logic [31:0] v, input string n);
    note(v, n);
    pin_go <= 1'b1;
    @(posedge clk);
    pin_go <= 1'b0;
  endtask
  task automatic kick(input logic [2:0] c);
    cmd  <= c;
    line <= 4'($urandom);
    go   <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_run();
    int n;
    n = 0;
    while (sys_n !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    cmp_count++;
    if (sys_n !== 1'b1) begin
      err_count++;
      $display("mismatch run_wait expected 1 seen %b", sys_n);
    end
  endtask
  task automatic check(input logic [31:0] s);
    pmc_note_t e;
    e = q.pop_front();
    cmp_count++;
    if (s !== e.v) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", e.n, e.v, s);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge clk) begin
    if (rd_go && hready === 1'b1) check(hrdata);
    else if (pin_go) check(obs);
  end
  // ****************
  // scenarios
  // ****************
  initial begin
    void'($urandom(19579));
    repeat (16) @(posedge clk);
    pins(32'h350, "reset_pins");
    rst_n <= 1'b1;
    wait_run();
    pins(32'h37f, "run_pins");
    rd(PMC_CTRL_ADDR, 32'h0, "ctrl_reset");
    rd(PMC_MASK_ADDR, 32'h0, "mask_reset");
    rd(8'h14, 32'h0, "unmapped");
    rd(PMC_STAT_ADDR, 32'h5, "status");
    det_above <= 1'b0;
    repeat (6) @(posedge clk);
    det_above <= 1'b1;
    repeat (6) @(posedge clk);
    rd(PMC_IRQ_ADDR, 32'h0, "irq_disabled");
    bus(PMC_MASK_ADDR, 1'b1, 32'h3);
    bus(PMC_CTRL_ADDR, 1'b1, 32'h1);
    repeat (2) @(posedge clk);
    det_above <= 1'b0;
    repeat (6) @(posedge clk);
    pins(32'h77f, "irq_fall_pin");
    rd(PMC_IRQ_ADDR, 32'h1, "irq_fall");
    bus(PMC_IRQ_ADDR, 1'b1, 32'h1);
    det_above <= 1'b1;
    repeat (6) @(posedge clk);
    rd(PMC_IRQ_ADDR, 32'h2, "irq_rise");
    bus(PMC_MASK_ADDR, 1'b1, 32'h0);
    pins(32'h37f, "irq_masked");
    bus(PMC_IRQ_ADDR, 1'b1, 32'h3);
    rd(PMC_IRQ_ADDR, 32'h0, "irq_cleared");
    kick(3'd0);
    pins(32'h37d, "sleep");
    kick(3'd1);
    pins(32'h37f, "sleep_wake");
    bus(PMC_ENTER_ADDR, 1'b1, $urandom);
    @(posedge clk);
    pins(32'h37d, "enter_sleep");
    kick(3'd2);
    pins(32'h37f, "line_wake");
    for (int lp = 0; lp < 2; lp++) begin
      bus(PMC_CTRL_ADDR, 1'b1, 32'h4 | (lp << 1));
      kick(3'd0);
      pins(lp ? 32'h3c1 : 32'h341, "stop");
      kick(lp ? 3'd3 : 3'd2);
      pins(32'h37f, "stop_wake");
      rd(PMC_CTRL_ADDR, 32'h4 | (lp << 1), "ctrl_kept");
      rd(PMC_IRQ_ADDR, 32'h4, "wake_flag");
      bus(PMC_IRQ_ADDR, 1'b1, 32'h4);
    end
    for (int s = 3; s < 7; s++) begin
      bus(PMC_CTRL_ADDR, 1'b1, 32'hc);
      kick(3'd0);
      pins(32'h200, "standby");
      kick(3'(s));
      wait_run();
      pins(32'h37f, "standby_exit");
      rd(PMC_CTRL_ADDR, 32'h0, "ctrl_lost");
    end
    supply_ok <= 1'b0;
    repeat (4) @(posedge clk);
    pins(32'h350, "supply_loss");
    supply_ok <= 1'b1;
    wait_run();
    conclude();
  end
  // whole run needs about 910 cycles
  initial begin
    repeat (30000) @(posedge clk);
    err_count++;
    conclude();
  end
endmodule
bind pmc_top pmc_monitor mon (.CLK_IN(CLK_IN), .RESET_N_IN(RESET_N_IN),
  .SUPPLY_OK_IN(SUPPLY_OK_IN), .CORE_EVENT_IN(CORE_EVENT_IN), .EXT_LINE_IN(EXT_LINE_IN),
  .RTC_EVENT_IN(RTC_EVENT_IN), .RESET_PIN_LOW_N_IN(RESET_PIN_LOW_N_IN),
  .WATCHDOG_RESET_IN(WATCHDOG_RESET_IN), .SYS_RESET_N_OUT(SYS_RESET_N_OUT),
  .CORE_CLK_EN_OUT(CORE_CLK_EN_OUT), .PERIPH_CLK_EN_OUT(PERIPH_CLK_EN_OUT),
  .PLL_EN_OUT(PLL_EN_OUT), .REG_EN_OUT(REG_EN_OUT), .REG_LOW_POWER_OUT(REG_LOW_POWER_OUT),
  .CORE_DOMAIN_PWR_OUT(CORE_DOMAIN_PWR_OUT), .BACKUP_CLK_EN_OUT(BACKUP_CLK_EN_OUT));
`default_nettype wire
